// ==== include/asram_pkg.sv ====
package asram_pkg;

    // Pin widths of the memory
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;

    // Controller clock period
    localparam int CLK_PERIOD_NS = 10;

    // Memory timing figures, fastest grade where printed
    localparam int ADDRESS_ACCESS_TIME_NS       = 10;
    localparam int OUTPUT_HOLD_AFTER_ADDRESS_NS = 3;
    localparam int SELECT_ACCESS_TIME_NS        = 10;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 5;
    localparam int LANE_ENABLE_ACCESS_TIME_NS   = 5;
    localparam int ADDRESS_SETUP_TO_END_NS      = 7;
    localparam int LANE_ENABLE_TO_END_NS        = 7;
    localparam int DATA_SETUP_TO_END_NS         = 6;
    localparam int DATA_HOLD_AFTER_END_NS       = 0;
    localparam int ADDRESS_HOLD_AFTER_END_NS    = 0;
    localparam int SUPPLY_TO_FIRST_ACCESS_US    = 100;
    localparam int OUTPUT_TURNOFF_NS            = 6;

    // Least times rounded up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_CYC     = ns_to_cyc(SELECT_ACCESS_TIME_NS);
    localparam int WRITE_CYC    = ns_to_cyc(ADDRESS_SETUP_TO_END_NS);
    localparam int TURN_CYC     = ns_to_cyc(OUTPUT_TURNOFF_NS);
    localparam int POWERUP_CYC  = (SUPPLY_TO_FIRST_ACCESS_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

    // Request from the user side
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        lane_en;
    } asram_req_t;

    // Control pins toward the memory, all active low
    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
        logic low_byte_lane_n;
        logic high_byte_lane_n;
    } asram_ctl_t;

    // Controller states
    typedef enum logic [2:0] {
        ASRAM_POWERUP,
        ASRAM_IDLE,
        ASRAM_READ,
        ASRAM_WRITE,
        ASRAM_WEND,
        ASRAM_TURN
    } asram_state_t;

endpackage

// ==== core/asram_counter.sv ====
`timescale 1ns/1ns
module asram_counter #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    // Load and status
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] value_i,
    output logic                  done_o
);

    logic [WIDTH-1:0] cnt_q;

    // Refuse a width that cannot hold a count
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least one");
    end

    // Counts down from the loaded value to zero
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= value_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done_o = (cnt_q == '0);

endmodule

// ==== core/asram_ctrl.sv ====
`timescale 1ns/1ns
// Summary of operation
// R01: write starts with select, strobe, lane low
// R02: write ends at first rising control
// R03: data timed against terminating edge
// R04: device stores only enabled byte lanes
// R05: read needs select, output enable, strobe high
// R06: device drives only enabled read lanes
// R07: device floats data when not reading
// R08: simultaneous rise keeps outputs floating
// R09: device turn-off faster than turn-on
// R10: address access time and output hold
// R11: select access time, address first
// R12: address valid by select falling edge
// R13: output enable access time
// R14: lane enable access time
// R15: address held through write end
// R16: data setup before end, zero hold
// R17: lane and select low before end
// R18: wait after power-up before access
// R19: deselect floats and powers down
// R20: eighteen address bits, sixteen-bit words
// R21: nanosecond minima rounded up to cycles
module asram_ctrl
    import asram_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC
) (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              nrst_i,
    // User request port
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire asram_req_t        req_i,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    // Memory address and control pins
    output logic [ADDR_W-1:0]      mem_addr_o,
    output asram_ctl_t             mem_ctl_o,
    // Memory data pins, split three ways
    input  wire logic [DATA_W-1:0] mem_dq_i,
    output logic [DATA_W-1:0]      mem_dq_o,
    output logic                   mem_dq_oe_n_o
);

    localparam int CNT_W    = 24;
    localparam int STEP_W   = 4;
    localparam int STEP_MAX = 1 << STEP_W;

    // Refuse counts and bus shapes the logic cannot serve
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << CNT_W)) begin : g_bad_boot
        $error("POWERUP_CYCLES out of range");
    end
    if (ADDR_W != 18 || DATA_W != 2 * LANE_W) begin : g_bad_shape
        $error("bus shape not served");
    end
    if (READ_CYC > STEP_MAX || WRITE_CYC > STEP_MAX || TURN_CYC > STEP_MAX) begin : g_bad_step
        $error("phase length exceeds step counter");
    end

    asram_state_t      state_q, state_d;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        lane_q;
    logic              rsp_q;
    logic              was_read_q;
    logic              step_load;
    logic [STEP_W-1:0] step_len;
    logic              boot_done;
    logic              step_done;
    logic              take;

    // Power-up wait before the first access
    logic [CNT_W-1:0] boot_q;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_q <= '0;
        end else if (boot_q != CNT_W'(POWERUP_CYCLES)) begin
            boot_q <= boot_q + 1'b1; // see R18
        end
    end
    assign boot_done = (boot_q == CNT_W'(POWERUP_CYCLES));

    // Decode of request acceptance and readiness
    assign take      = (state_q == ASRAM_IDLE) && req_valid_i && (req_i.lane_en != 2'b00);
    assign req_ready_o = (state_q == ASRAM_IDLE) && (req_i.lane_en != 2'b00);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ASRAM_POWERUP: if (boot_done) state_d = ASRAM_IDLE;
            ASRAM_IDLE:    if (take) state_d = req_i.write ? ASRAM_WRITE : ASRAM_READ;
            ASRAM_READ:    if (step_done) state_d = ASRAM_TURN;
            ASRAM_WRITE:   if (step_done) state_d = ASRAM_WEND;
            ASRAM_WEND:    state_d = ASRAM_TURN;
            ASRAM_TURN:    if (step_done) state_d = ASRAM_IDLE;
            default:       state_d = ASRAM_IDLE;
        endcase
    end

    // Phase length in whole cycles, reloaded on every state change
    assign step_load = (state_d != state_q);
    assign step_len  = (state_d == ASRAM_READ)  ? STEP_W'(READ_CYC - 1)  : // see R21
                       (state_d == ASRAM_WRITE) ? STEP_W'(WRITE_CYC - 1) : // see R21
                       (state_d == ASRAM_TURN)  ? STEP_W'(TURN_CYC - 1)  : '0;

    // Phase counter; done while the current phase has run out
    asram_counter #(.WIDTH(STEP_W)) u_step (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .load_i     (step_load),
        .value_i    (step_len),
        .done_o     (step_done)
    );

    // Latched request, held for the whole access
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ASRAM_POWERUP;
            addr_q     <= '0;
            wdata_q    <= '0;
            lane_q     <= '0;
            was_read_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take) begin
                addr_q     <= req_i.addr;     // see R12 R15 R20
                wdata_q    <= req_i.wdata;    // see R16
                lane_q     <= req_i.lane_en;
                was_read_q <= !req_i.write;
            end
        end
    end

    // Read data capture at the end of the access time
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
            rsp_q   <= 1'b0;
        end else begin
            rsp_q <= (state_q == ASRAM_READ) && step_done;
            if ((state_q == ASRAM_READ) && step_done) begin
                rdata_q <= {lane_q[1] ? mem_dq_i[DATA_W-1:LANE_W] : 8'h00,
                            lane_q[0] ? mem_dq_i[LANE_W-1:0] : 8'h00}; // see R10 R11 R13 R14
            end
        end
    end
    assign rsp_valid_o = rsp_q;
    assign rsp_rdata_o = rdata_q;

    // Pin drive decode
    wire active   = (state_q == ASRAM_READ) || (state_q == ASRAM_WRITE);
    wire in_write = (state_q == ASRAM_WRITE);
    wire in_read  = (state_q == ASRAM_READ);
    // Select, lanes and address stay through the write; strobe rises first
    assign mem_ctl_o.chip_sel_n       = !(active || (state_q == ASRAM_WEND)); // see R02 R17
    assign mem_ctl_o.write_n          = !in_write;                            // see R01 R02
    assign mem_ctl_o.out_en_n         = !in_read;                             // see R05
    assign mem_ctl_o.low_byte_lane_n  = !((active || state_q == ASRAM_WEND) && lane_q[0]);
    assign mem_ctl_o.high_byte_lane_n = !((active || state_q == ASRAM_WEND) && lane_q[1]);
    assign mem_addr_o                 = addr_q;
    // Data driven through the strobe rise, released after it
    assign mem_dq_o      = wdata_q;                                            // see R03
    assign mem_dq_oe_n_o = !(in_write || (state_q == ASRAM_WEND && !was_read_q)); // see R16

    // Assertions
    a_no_access_boot: assert property ( // see R18
        @(posedge core_clk_i) disable iff (!nrst_i)
        !boot_done |-> mem_ctl_o.chip_sel_n)
        else $error("access before power-up wait");
    a_ready_boot: assert property ( // see R18
        @(posedge core_clk_i) disable iff (!nrst_i)
        req_ready_o |-> boot_done && mem_ctl_o.chip_sel_n)
        else $error("ready before power-up wait or while busy");
    a_read_strobe_high: assert property ( // see R05
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_ctl_o.out_en_n |-> mem_ctl_o.write_n && !mem_ctl_o.chip_sel_n)
        else $error("read without select or with strobe low");
    a_read_lanes: assert property ( // see R05
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_ctl_o.out_en_n |-> !(mem_ctl_o.low_byte_lane_n && mem_ctl_o.high_byte_lane_n))
        else $error("read with no lane enabled");
    a_write_overlap: assert property ( // see R01
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_ctl_o.write_n |-> !mem_ctl_o.chip_sel_n &&
        !(mem_ctl_o.low_byte_lane_n && mem_ctl_o.high_byte_lane_n))
        else $error("strobe low without select and lane");
    a_lanes_match: assert property ( // see R01
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_ctl_o.chip_sel_n |->
        ({!mem_ctl_o.high_byte_lane_n, !mem_ctl_o.low_byte_lane_n} == lane_q))
        else $error("lane enables differ from request");
    a_write_length: assert property ( // see R17 R21
        @(posedge core_clk_i) disable iff (!nrst_i)
        $fell(mem_ctl_o.write_n) |-> !mem_ctl_o.write_n [*1] ##1 mem_ctl_o.write_n)
        else $error("write pulse length wrong");
    a_select_with_strobe: assert property ( // see R12 R17
        @(posedge core_clk_i) disable iff (!nrst_i)
        $fell(mem_ctl_o.write_n) |-> $fell(mem_ctl_o.chip_sel_n))
        else $error("select not lowered with strobe");
    a_strobe_ends: assert property ( // see R02 R03
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(mem_ctl_o.write_n) |-> !mem_ctl_o.chip_sel_n && !mem_dq_oe_n_o)
        else $error("write not ended by strobe");
    a_select_after_end: assert property ( // see R02 R15
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(mem_ctl_o.write_n) |-> ##1 mem_ctl_o.chip_sel_n)
        else $error("select not released after write end");
    a_lanes_to_end: assert property ( // see R17
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(mem_ctl_o.write_n) |-> !(mem_ctl_o.low_byte_lane_n && mem_ctl_o.high_byte_lane_n))
        else $error("lanes released before write end");
    a_addr_hold_end: assert property ( // see R15
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(mem_ctl_o.write_n) |-> $stable(mem_addr_o))
        else $error("address moved at write end");
    a_data_hold_end: assert property ( // see R16
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(mem_ctl_o.write_n) |-> $stable(mem_dq_o))
        else $error("write data moved at write end");
    a_addr_stable: assert property ( // see R12 R15
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_ctl_o.chip_sel_n && !$past(mem_ctl_o.chip_sel_n) |-> $stable(mem_addr_o))
        else $error("address moved during access");
    a_data_stable: assert property ( // see R16
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_dq_oe_n_o && !$past(mem_dq_oe_n_o) |-> $stable(mem_dq_o))
        else $error("write data moved");
    a_release_deselect: assert property ( // see R02
        @(posedge core_clk_i) disable iff (!nrst_i)
        mem_ctl_o.chip_sel_n |-> mem_dq_oe_n_o && mem_ctl_o.write_n && mem_ctl_o.out_en_n)
        else $error("pins active while deselected");
    a_no_contention: assert property ( // see R07
        @(posedge core_clk_i) disable iff (!nrst_i)
        !mem_dq_oe_n_o |-> mem_ctl_o.out_en_n)
        else $error("bus driven while memory may drive");
    a_turnaround: assert property ( // see R09
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(mem_ctl_o.out_en_n) |-> mem_dq_oe_n_o)
        else $error("drive right after read");
    a_read_rsp: assert property ( // see R11
        @(posedge core_clk_i) disable iff (!nrst_i)
        $fell(mem_ctl_o.out_en_n) |-> ##1 rsp_valid_o)
        else $error("read answer not on time");

endmodule

// ==== test/asram_mem_model.sv ====
`timescale 1ns/1ns
module asram_mem_model
    import asram_pkg::*;
#(
    parameter int ACC_NS = 8
) (
    // Pins from the controller
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire asram_ctl_t        ctl_i,
    input  wire logic [DATA_W-1:0] dq_i,
    // Data back toward the controller
    output logic [DATA_W-1:0]      dq_o,
    output logic                   drive_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] held = 16'h5a5a;
    logic [ADDR_W-1:0] w_addr;
    logic [DATA_W-1:0] w_data;
    logic [1:0]        w_lane;
    wire  [1:0]        en_dly;
    wire  [1:0]        lane_on = {~ctl_i.high_byte_lane_n, ~ctl_i.low_byte_lane_n};
    // Write window and read select decode
    wire wr_act = !ctl_i.chip_sel_n && !ctl_i.write_n && (lane_on != 2'b00);
    wire rd_sel = !ctl_i.chip_sel_n && !ctl_i.out_en_n && ctl_i.write_n;
    wire [1:0] en_now = rd_sel ? lane_on : 2'b00;
    // Slow turn-on, immediate turn-off
    assign #(ACC_NS, 0) en_dly[0] = en_now[0];
    assign #(ACC_NS, 0) en_dly[1] = en_now[1];
    // Track what the open write carries
    always @* begin
        if (wr_act) begin
            w_addr = addr_i;
            w_data = dq_i;
            w_lane = lane_on;
        end
    end
    // Store enabled lanes when the first control rises
    always @(negedge wr_act) begin
        if (w_lane[0]) mem[w_addr][7:0] = w_data[7:0];
        if (w_lane[1]) mem[w_addr][15:8] = w_data[15:8];
    end
    // Released lanes show the inverse of the last data
    always @* begin
        if (en_dly != 2'b00) held = mem[addr_i];
    end
    assign dq_o = {en_dly[1] ? mem[addr_i][15:8] : ~held[15:8],
                   en_dly[0] ? mem[addr_i][7:0] : ~held[7:0]};
    assign drive_o = (en_dly != 2'b00);
endmodule

// ==== test/asram_ctrl_tb.sv ====
`timescale 1ns/1ns
module asram_ctrl_tb;
    import asram_pkg::*;
    localparam int PU = 20;
    logic              core_clk_i  = 1'b0;
    logic              nrst_i      = 1'b0;
    logic              req_valid_i = 1'b0;
    asram_req_t        req_i       = '0;
    wire               req_ready_o;
    wire               rsp_valid_o;
    wire               mem_dq_oe_n_o;
    wire               drive;
    wire [DATA_W-1:0]  rsp_rdata_o;
    wire [DATA_W-1:0]  mem_dq_o;
    wire [DATA_W-1:0]  mdl_dq;
    wire [DATA_W-1:0]  dq_bus;
    wire [ADDR_W-1:0]  mem_addr_o;
    wire asram_ctl_t   mem_ctl_o;
    int                errors = 0;
    int                checks_done = 0;
    int                cyc = 0;
    integer            seed = 97;
    logic [DATA_W-1:0] mirror [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] exp_q [$];

    // Clock and bus resolution
    always #5 core_clk_i = ~core_clk_i;
    assign dq_bus = mem_dq_oe_n_o ? mdl_dq : mem_dq_o;

    asram_ctrl #(.POWERUP_CYCLES(PU)) i_asram_ctrl (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o), .mem_ctl_o(mem_ctl_o),
        .mem_dq_i(dq_bus), .mem_dq_o(mem_dq_o), .mem_dq_oe_n_o(mem_dq_oe_n_o));
    asram_mem_model i_asram_mem_model (
        .addr_i(mem_addr_o), .ctl_i(mem_ctl_o), .dq_i(dq_bus), .dq_o(mdl_dq),
        .drive_o(drive));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Hold a request until its take edge, then note the outcome
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic [1:0] ln);
        logic [DATA_W-1:0] m;
        req_valid_i = 1'b1;
        req_i = '{write: wr, addr: a, wdata: d, lane_en: ln};
        while (req_ready_o !== 1'b1) begin
            @(posedge core_clk_i);
            #1;
        end
        @(posedge core_clk_i);
        m = mirror.exists(a) ? mirror[a] : 16'h0000;
        if (wr) begin
            if (ln[0]) m[7:0] = d[7:0];
            if (ln[1]) m[15:8] = d[15:8];
            mirror[a] = m;
        end else begin
            exp_q.push_back(m & {{8{ln[1]}}, {8{ln[0]}}});
        end
        #1;
    endtask

    // Watch responses, bus ownership and the run length
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 2000) begin
            errors++;
            give_verdict();
        end
        if (rsp_valid_o === 1'b1) begin
            if (exp_q.size() == 0) check(rsp_valid_o, 1'b0);
            else check(rsp_rdata_o, exp_q.pop_front());
        end
        if (mem_dq_oe_n_o === 1'b0) check(drive, 1'b0);
    end

    // Main sequence
    initial begin
        int n;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        req_i.lane_en = 2'b11;
        repeat (16) @(posedge core_clk_i);
        #1;
        nrst_i = 1'b1;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        check(n, PU + 1);
        // An empty lane set is never taken
        req_valid_i = 1'b1;
        req_i.lane_en = 2'b00;
        repeat (4) begin
            @(posedge core_clk_i);
            #1;
            check(req_ready_o, 1'b0);
        end
        // Back-to-back writes and reads over every non-empty lane set
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 18'h0_0000 : (i == 1) ? 18'h3_ffff : ADDR_W'($random(seed));
            d = 16'($random(seed));
            issue(1'b1, a, d, 2'b11);
            issue(1'b0, a, 16'h0000, 2'b11);
            issue(1'b1, a, ~d, 2'b01);
            issue(1'b1, a, 16'($random(seed)), 2'b10);
            issue(1'b0, a, 16'h0000, 2'b01);
            issue(1'b0, a, 16'h0000, 2'b10);
            issue(1'b0, a, 16'h0000, 2'b11);
        end
        req_valid_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        check(exp_q.size(), 0);
        give_verdict();
    end
endmodule
